// ### design/spa_pkg.sv
// shared definitions for the saturating pixel adder
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package spa_pkg;

  // ---------------------------------------------------------------------------
  // datapath geometry
  // ---------------------------------------------------------------------------
  localparam int          SPA_LANE_W   = 8;
  localparam int          SPA_LANES    = 8;
  localparam int          SPA_DATA_W   = 64;
  localparam int          SPA_HALF_W   = 32;
  localparam logic [63:0] SPA_RES_RST  = 64'h0;

  // compare result bit positions
  localparam int SPA_CMP_BOTH_GE = 4;
  localparam int SPA_CMP_BOTH_LT = 5;
  localparam int SPA_CMP_HI_GE   = 6;
  localparam int SPA_CMP_LO_GE   = 7;
  localparam int SPA_CMP_INV     = 4;  // offset of the inverted group

  // ---------------------------------------------------------------------------
  // operation, saturation form and field size encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    SPA_OP_ADD  = 5'h01,
    SPA_OP_ADDS = 5'h02,
    SPA_OP_SUB  = 5'h04,
    SPA_OP_SUBS = 5'h08,
    SPA_OP_CMP  = 5'h10
  } spa_op_type;

  typedef enum logic [2:0] {
    SPA_FORM_UNSIGNED          = 3'h1,
    SPA_FORM_SIGNED            = 3'h2,
    SPA_FORM_MIXED_SIGN_SAT    = 3'h4   // mixed_sign_saturation_form
  } spa_form_type;

  typedef enum logic [2:0] {
    SPA_SIZE_BYTE = 3'h1,
    SPA_SIZE_HALF = 3'h2,
    SPA_SIZE_WORD = 3'h4
  } spa_size_type;

endpackage : spa_pkg

// ### design/spa_saturating_pixel_adder.sv
// packed field adder with modulo and saturating arithmetic and dual compare
module spa_saturating_pixel_adder (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // operation request from issue logic
  input  wire logic                  valid_i,
  input  wire spa_pkg::spa_op_type   op_i,
  input  wire spa_pkg::spa_form_type form_i,
  input  wire spa_pkg::spa_size_type size_i,
  input  wire logic [63:0]           src1_i,
  input  wire logic [63:0]           src2_i,
  // result to register file
  output logic                       valid_o,
  output logic [63:0]                result_o
);
  import spa_pkg::*;

  // ---------------------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------------------
  // the lane logic is written for byte lanes, 8-bit clamps and two word
  // halves; refuse any other geometry rather than build a wrong adder
  if (SPA_LANE_W != 8) begin : g_chk_lane
    $error("lane width must be 8 bits");
  end
  if (SPA_DATA_W != 64 || SPA_LANES * SPA_LANE_W != SPA_DATA_W) begin : g_chk_data
    $error("eight byte lanes must fill the 64-bit operands");
  end
  if (2 * SPA_HALF_W != SPA_DATA_W) begin : g_chk_half
    $error("the two adders must each take half of the operands");
  end
  if (SPA_CMP_LO_GE + SPA_CMP_INV >= SPA_HALF_W) begin : g_chk_cmp
    $error("compare code must fit in the low word");
  end

  // ---------------------------------------------------------------------------
  // lane helpers
  // ---------------------------------------------------------------------------
  // lane that holds the top bits of the field containing lane l
  function automatic int unsigned top_lane(input int unsigned l, input spa_size_type sz);
    int unsigned t;
    t = l;
    if (sz == SPA_SIZE_HALF) begin
      t = l | 1;
    end else if (sz == SPA_SIZE_WORD) begin
      t = l | 3;
    end
    return t;
  endfunction

  // lane that starts a field: carry chain is broken below it
  function automatic logic is_base(input int unsigned l, input spa_size_type sz);
    logic b;
    b = 1'b1;
    if (sz == SPA_SIZE_HALF) begin
      b = (l % 2) == 0;
    end else if (sz == SPA_SIZE_WORD) begin
      b = (l % 4) == 0;
    end
    return b;
  endfunction

  // ---------------------------------------------------------------------------
  // operation decode
  // ---------------------------------------------------------------------------
  // codes that are not one-hot fall through to a modulo add: the issue logic
  // never sends them, and a plain add is the cheapest harmless answer
  logic is_sub;
  logic is_sat;
  assign is_sub = (op_i == SPA_OP_SUB) || (op_i == SPA_OP_SUBS);
  assign is_sat = (op_i == SPA_OP_ADDS) || (op_i == SPA_OP_SUBS);

  // ---------------------------------------------------------------------------
  // byte-lane adders: eight lanes form two 32-bit adders
  // ---------------------------------------------------------------------------
  // lane 0 holds bits 7:0; a halfword is a lane pair, a word four lanes. each
  // lane keeps its own carry into and out of bit 7, so saturation of a wide
  // field is judged only at the lane that holds the field's top bit. the whole
  // chain settles within one clock, which keeps one result per clock with no
  // stall, paid for with a 32-bit ripple path
  logic [SPA_LANES-1:0] carry_out;   // carry out of lane bit 7
  logic [SPA_LANES-1:0] carry_msb;   // carry into lane bit 7
  logic [SPA_LANES-1:0] a_msb;
  logic [SPA_LANES-1:0] b_msb;       // effective (inverted on subtract) second operand
  logic [SPA_LANES-1:0] s_msb;
  logic [63:0]          sum_mod;
  logic [63:0]          sum_sat;

  genvar l;
  generate
    for (l = 0; l < SPA_LANES; l++) begin : g_lane
      logic [7:0] a_b;
      logic [7:0] b_b;
      logic       cin;
      logic [8:0] full;
      logic [7:0] low;
      logic       sat;
      logic       to_max;
      logic [7:0] clamp;
      int unsigned t;

      assign a_b = src1_i[l*SPA_LANE_W +: SPA_LANE_W];
      // subtract as a plus inverted b plus one, carry out means no borrow
      assign b_b = is_sub ? ~src2_i[l*SPA_LANE_W +: SPA_LANE_W]
                          :  src2_i[l*SPA_LANE_W +: SPA_LANE_W];

      // carry is forced at field bases; 32-bit halves never chain
      if (l == 0 || l == SPA_LANES / 2) begin : g_cin0
        assign cin = is_sub;
      end else begin : g_cinn
        assign cin = is_base(l, size_i) ? is_sub : carry_out[l-1];
      end

      assign full = {1'b0, a_b} + {1'b0, b_b} + {8'h00, cin};
      assign low  = {1'b0, a_b[6:0]} + {1'b0, b_b[6:0]} + {7'h00, cin};
      assign carry_out[l] = full[8];
      assign carry_msb[l] = low[7];
      assign a_msb[l]     = a_b[7];
      assign b_msb[l]     = b_b[7];
      assign s_msb[l]     = full[7];
      assign sum_mod[l*SPA_LANE_W +: SPA_LANE_W] = full[7:0];

      // saturation decided from the field's top lane only
      assign t = top_lane(l, size_i);

      always_comb begin
        sat    = 1'b0;
        to_max = 1'b0;
        clamp  = 8'h00;
        if (form_i == SPA_FORM_UNSIGNED) begin
          // add carries out, subtract borrows (no carry)
          sat    = is_sub ? ~carry_out[t] : carry_out[t];
          to_max = ~is_sub;
          // add then subtract of one constant thus clamps to a ceiling
          clamp  = to_max ? 8'hff : 8'h00;
        end else if (form_i == SPA_FORM_SIGNED) begin
          sat    = carry_msb[t] ^ carry_out[t];
          to_max = ~carry_out[t];
          // top lane carries the sign bit, lower lanes fill
          if (l == t) begin
            clamp = to_max ? 8'h7f : 8'h80;
          end else begin
            clamp = to_max ? 8'hff : 8'h00;
          end
        end else if (form_i == SPA_FORM_MIXED_SIGN_SAT) begin
          // effective operand sign already folds in the subtract
          sat    = (a_msb[t] ^ b_msb[t]) & ~(b_msb[t] ^ s_msb[t]);
          to_max = ~b_msb[t];
          clamp  = to_max ? 8'hff : 8'h00;
        end
      end

      // unsaturated fields keep the modulo result
      assign sum_sat[l*SPA_LANE_W +: SPA_LANE_W] = sat ? clamp : full[7:0];
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // dual unsigned 32-bit compare
  // ---------------------------------------------------------------------------
  // only bits 4..11 carry the code; all else is zero so that a full-width
  // write of the answer leaves no stale bits behind
  logic        hi_ge;
  logic        lo_ge;
  logic [63:0] cmp_res;
  assign hi_ge = src1_i[63:32] >= src2_i[63:32];
  assign lo_ge = src1_i[31:0]  >= src2_i[31:0];

  always_comb begin
    cmp_res                  = 64'h0;
    cmp_res[SPA_CMP_BOTH_GE] =  hi_ge &  lo_ge;
    cmp_res[SPA_CMP_BOTH_LT] = ~hi_ge & ~lo_ge;
    cmp_res[SPA_CMP_HI_GE]   =  hi_ge & ~lo_ge;
    cmp_res[SPA_CMP_LO_GE]   = ~hi_ge &  lo_ge;
    cmp_res[SPA_CMP_BOTH_GE+SPA_CMP_INV] = ~( hi_ge &  lo_ge);
    cmp_res[SPA_CMP_BOTH_LT+SPA_CMP_INV] = ~(~hi_ge & ~lo_ge);
    cmp_res[SPA_CMP_HI_GE+SPA_CMP_INV]   = ~( hi_ge & ~lo_ge);
    cmp_res[SPA_CMP_LO_GE+SPA_CMP_INV]   = ~(~hi_ge &  lo_ge);
  end

  // ---------------------------------------------------------------------------
  // result select and output register
  // ---------------------------------------------------------------------------
  logic [63:0] result_nxt;
  always_comb begin
    if (op_i == SPA_OP_CMP) begin
      result_nxt = cmp_res;
    end else if (is_sat) begin
      result_nxt = sum_sat;
    end else begin
      result_nxt = sum_mod;
    end
  end

  // one operation per clock, result one clock later; no stall is needed
  logic        valid_r;
  logic [63:0] result_r;

  // answer flag: one pulse per accepted operation, high throughout a
  // back-to-back stream since a new operation is taken every clock
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= valid_i;
    end
  end

  // result stands through idle slots, so a late reader still finds it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      result_r <= SPA_RES_RST;
    end else if (valid_i) begin
      result_r <= result_nxt;
    end
  end

  // outputs come straight from the flip-flops above
  assign valid_o  = valid_r;
  assign result_o = result_r;

endmodule // spa_saturating_pixel_adder

// ### verification/spa_adder_checker.sv
// port assertions for the pixel adder
module spa_adder_checker (
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  valid_i,
  input wire spa_pkg::spa_op_type   op_i,
  input wire spa_pkg::spa_form_type form_i,
  input wire spa_pkg::spa_size_type size_i,
  input wire logic [63:0]           src1_i,
  input wire logic [63:0]           src2_i,
  input wire logic                  valid_o,
  input wire logic [63:0]           result_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import spa_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // each op answers one clock later, idle slots hold the result
  one_clock_answer_a: assert property (
    $past(rst_n_i) |-> valid_o == $past(valid_i))
    else $error("late answer");
  idle_result_hold_a: assert property (
    $past(rst_n_i && !valid_i) |-> $stable(result_o))
    else $error("no hold");
  // compare frame: coded bits 4..11 only, upper group inverted
  compare_frame_a: assert property (
    $past(rst_n_i && valid_i && op_i == SPA_OP_CMP) |->
    result_o[3:0] == 4'h0 && result_o[63:12] == 52'h0 && result_o[11:8] == ~result_o[7:4])
    else $error("bad compare frame");
  compare_both_ge_a: assert property (
    $past(rst_n_i && valid_i && op_i == SPA_OP_CMP) |->
    result_o[4] == $past(src1_i[63:32] >= src2_i[63:32] && src1_i[31:0] >= src2_i[31:0]))
    else $error("bad ge bit");
  // unsigned clamps on the low byte lane
  unsigned_add_clamp_a: assert property (
    $past(rst_n_i && valid_i && op_i == SPA_OP_ADDS && form_i == SPA_FORM_UNSIGNED && size_i == SPA_SIZE_BYTE
    && 9'(src1_i[7:0]) + 9'(src2_i[7:0]) > 9'h0ff) |-> result_o[7:0] == 8'hff)
    else $error("no add clamp");
  unsigned_sub_clamp_a: assert property (
    $past(rst_n_i && valid_i && op_i == SPA_OP_SUBS && form_i == SPA_FORM_UNSIGNED && size_i == SPA_SIZE_BYTE
    && src1_i[7:0] < src2_i[7:0]) |-> result_o[7:0] == 8'h00)
    else $error("no sub clamp");
  // mixed form: unsigned plus a positive value that overflows goes to all ones
  mixed_add_clamp_a: assert property (
    $past(rst_n_i && valid_i && op_i == SPA_OP_ADDS && form_i == SPA_FORM_MIXED_SIGN_SAT
    && size_i == SPA_SIZE_BYTE && !src2_i[7] && 9'(src1_i[7:0]) + 9'(src2_i[7:0]) > 9'h0ff)
    |-> result_o[7:0] == 8'hff)
    else $error("no mixed clamp");
  // modulo fields wrap without carry across the field edge
  word_add_wrap_a: assert property (
    $past(rst_n_i && valid_i && op_i == SPA_OP_ADD && size_i == SPA_SIZE_WORD) |->
    result_o == {$past(src1_i[63:32] + src2_i[63:32]), $past(src1_i[31:0] + src2_i[31:0])})
    else $error("word add");
  half_sub_wrap_a: assert property (
    $past(rst_n_i && valid_i && op_i == SPA_OP_SUB && size_i == SPA_SIZE_HALF) |->
    result_o[31:16] == $past(src1_i[31:16] - src2_i[31:16]))
    else $error("half sub");
endmodule // spa_adder_checker

bind spa_saturating_pixel_adder spa_adder_checker i_chk (.clk_i, .rst_n_i, .valid_i, .op_i, .form_i, .size_i,
  .src1_i, .src2_i, .valid_o, .result_o);

// ### verification/spa_issue_model.sv
// issue logic model presenting at most one operation per clock
module spa_issue_model (
  input  wire logic             clk_i,
  output logic                  valid_o,
  output spa_pkg::spa_op_type   op_o,
  output spa_pkg::spa_form_type form_o,
  output spa_pkg::spa_size_type size_o,
  output logic [63:0]           src1_o,
  output logic [63:0]           src2_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import spa_pkg::*;
  initial begin
    {valid_o, src1_o, src2_o} = '0;
    op_o = SPA_OP_ADD;
    form_o = SPA_FORM_UNSIGNED;
    size_o = SPA_SIZE_BYTE;
  end
  // one slot per edge; idle slots scramble operands so stale data never looks valid
  task automatic issue(input logic v, input logic [4:0] op, input logic [2:0] fm, sz, input logic [63:0] a, b);
    @(posedge clk_i);
    #1;
    valid_o = v;
    op_o = spa_op_type'(op);
    form_o = spa_form_type'(fm);
    size_o = spa_size_type'(sz);
    src1_o = v ? a : ~src1_o;
    src2_o = v ? b : ~src2_o;
  endtask
endmodule // spa_issue_model

// ### verification/spa_saturating_pixel_adder_tb.sv
// self-checking bench for the pixel adder
module spa_saturating_pixel_adder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import spa_pkg::*;
  logic clk_i = 0, rst_n_i = 0, valid_i, valid_o, pend = 0;
  spa_op_type op_i;
  spa_form_type form_i;
  spa_size_type size_i;
  logic [63:0] src1_i, src2_i, result_o, exp_r = 0, a, b, c;
  logic [7:0] cor [6] = '{8'h00, 8'h55, 8'h7f, 8'h80, 8'haa, 8'hff};
  int n_fail = 0, check_count = 0, seed = 38;
  always #10 clk_i = ~clk_i;
  spa_saturating_pixel_adder i_dut (.clk_i, .rst_n_i, .valid_i, .op_i, .form_i, .size_i, .src1_i, .src2_i,
    .valid_o, .result_o);
  spa_issue_model i_iss (.clk_i, .valid_o(valid_i), .op_o(op_i), .form_o(form_i), .size_o(size_i),
    .src1_o(src1_i), .src2_o(src2_i));
  // reference per field: wrap, then clamp by form
  function automatic logic [63:0] exp_f(input logic [4:0] op, input logic [2:0] fm, sz, input logic [63:0] a, b);
    logic [63:0] r;
    logic [32:0] m, x, y, s;
    logic h, l, sub, st;
    int w;
    r = 64'h0;
    h = a[63:32] >= b[63:32];
    l = a[31:0] >= b[31:0];
    if (op == 5'h10) return {52'h0, ~{!h & l, h & !l, !h & !l, h & l}, !h & l, h & !l, !h & !l, h & l, 4'h0};
    w = sz[0] ? 8 : sz[1] ? 16 : 32;
    m = (33'h1 << w) - 33'h1;
    sub = op[2] | op[3];
    st = op[1] | op[3];
    for (int f = 0; f < 64; f += w) begin
      x = 33'(a >> f) & m;
      y = (sub ? ~33'(b >> f) : 33'(b >> f)) & m;
      s = x + y + 33'(sub);
      if (st && fm == 3'h1 && s[w] != sub) s = sub ? 33'h0 : m;
      if (st && fm == 3'h2 && x[w-1] == y[w-1] && s[w-1] != x[w-1]) s = x[w-1] ? (m >> 1) + 33'h1 : m >> 1;
      if (st && fm == 3'h4 && x[w-1] != y[w-1] && y[w-1] == s[w-1]) s = y[w-1] ? 33'h0 : m;
      r = r | (64'(s & m) << f);
    end
    return r;
  endfunction
  task automatic check(input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // fixed latency: each slot checks the answer to the slot before
  task automatic step(input logic v, input logic [4:0] op, input logic [2:0] fm, sz, input logic [63:0] a, b);
    i_iss.issue(v, op, fm, sz, a, b);
    check(64'(valid_o), 64'(pend));
    check(result_o, exp_r);
    pend = v;
    if (v) exp_r = exp_f(op, fm, sz, a, b);
  endtask
  task automatic direct(input logic [4:0] op, input logic [2:0] fm, input logic [7:0] x, y, e);
    step(1, op, fm, 3'h1, {8{x}}, {8{y}});
    exp_r = {8{e}};
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    #1 rst_n_i = 1;
    direct(5'h01, 3'h1, 8'h80, 8'h80, 8'h00);
    direct(5'h02, 3'h2, 8'h55, 8'h55, 8'h7f);
    direct(5'h02, 3'h1, 8'h80, 8'h80, 8'hff);
    direct(5'h02, 3'h4, 8'h55, 8'h80, 8'h00);
    direct(5'h02, 3'h1, 8'h55, 8'h55, 8'haa);
    direct(5'h02, 3'h2, 8'haa, 8'haa, 8'h80);
    direct(5'h02, 3'h4, 8'haa, 8'h7f, 8'hff);
    direct(5'h08, 3'h1, 8'h10, 8'h20, 8'h00);
    direct(5'h08, 3'h2, 8'h7f, 8'hff, 8'h7f);
    direct(5'h08, 3'h4, 8'hf0, 8'h90, 8'hff);
    direct(5'h08, 3'h4, 8'h10, 8'h20, 8'h00);
    // clamp to a ceiling by saturating up then back down
    a = 64'h0040cfd0ff7f10e5;
    step(1, 5'h02, 3'h1, 3'h1, a, {8{8'h30}});
    step(1, 5'h08, 3'h1, 3'h1, exp_r, {8{8'h30}});
    for (int j = 0; j < 64; j += 8) c[j+:8] = a[j+:8] > 8'hcf ? 8'hcf : a[j+:8];
    exp_r = c;
    // random ops, forms and sizes over mixed corner lanes on even passes and random operands on odd ones, with idle gaps
    for (int i = 0; i < 3000; i++) begin
      for (int j = 0; j < 64; j += 8) begin
        a[j+:8] = cor[unsigned'($random(seed)) % 6];
        b[j+:8] = cor[unsigned'($random(seed)) % 6];
      end
      if (i % 2) {a, b} = {$random(seed), $random(seed), $random(seed), $random(seed)};
      step(i % 7 != 3, 5'h01 << (unsigned'($random(seed)) % 5), 3'h1 << (unsigned'($random(seed)) % 3),
        3'h1 << (unsigned'($random(seed)) % 3), a, b);
    end
    step(0, 5'h01, 3'h1, 3'h1, a, b);
    end_of_test();
  end
endmodule // spa_saturating_pixel_adder_tb
